// [logic/tvp_pkg.sv]
// Package for the TLB victim index and page attribute block.
// Assumes a single core clock and a classic Wishbone register port.
package tvp_pkg;
    // ==========================================================
    // Geometry
    localparam int          TLB_ENTRIES = 32;
    localparam int          IDX_W       = $clog2(TLB_ENTRIES);
    localparam logic [4:0]  IDX_TOP     = 5'(TLB_ENTRIES - 1);
    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_VICTIM = 8'h00;
    localparam logic [7:0] OFS_EVEN   = 8'h04;
    localparam logic [7:0] OFS_ODD    = 8'h08;
    localparam logic [7:0] OFS_PINNED = 8'h0C;
    localparam logic [7:0] OFS_CTL    = 8'h10;
    localparam logic [7:0] OFS_CAP    = 8'h14;
    // ==========================================================
    // Attribute field positions
    localparam int ATTR_LOAD_INH  = 31;
    localparam int ATTR_FETCH_BLK = 30;
    localparam int ATTR_FN_LO     = 6;
    localparam int ATTR_FN_HI     = 25;
    localparam int ATTR_MT_LO     = 3;
    localparam int ATTR_MT_HI     = 5;
    localparam int ATTR_STORE_OK  = 2;
    localparam int ATTR_VALID     = 1;
    localparam int ATTR_SHARED    = 0;
    // Control register bits
    localparam int CTL_LI_EN = 0;
    localparam int CTL_FB_EN = 1;
    localparam int CTL_SP_EN = 2;
    // Reset values
    localparam logic [31:0] ATTR_RST = 32'h0000_0000;
    localparam logic [4:0]  LFSR_SEED = 5'h15;
    // Memory types after decoding
    typedef enum logic [1:0] {MT_WT_NOALLOC, MT_WT_ALLOC, MT_UNCACHED, MT_WB_ALLOC} tvp_mtype_t;
endpackage : tvp_pkg

// [logic/tvp_core.sv]
// TLB victim index generator, page attribute registers, TLB entry array
// and translation check. Assumes the pipeline gives one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - victim index read-only, five bits, upper zero
// - random write uses current victim index
// - lowest index equals pinned entry count
// - highest index is entries minus one
// - decrement on clocks the LFSR does not stall, wrap at pinned count
// - LFSR randomly suppresses the decrement
// - even and odd attribute registers carry entries
// - load inhibit faults loads when enabled
// - fetch block faults fetches when enabled
// - frame number shift depends on small pages
// - store permit zero raises modified fault
// - valid zero raises invalid fault
// - stored shared flag is AND of both
// - shared entry skips space id compare
// - TLB read copies shared flag to both
// - decode memory type codes zero to three
// - codes four-six are write-back, seven uncached
// - writes to read-only fields are ignored
module tvp_core (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [31:0]          wb_dat_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic                 wb_we_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    output logic                      wb_err_o,
    input  wire logic                 tlb_write_victim,
    input  wire logic                 tlb_write_indexed,
    input  wire logic                 tlb_read_entry,
    input  wire logic [tvp_pkg::IDX_W-1:0] entry_index,
    input  wire logic [18:0]          wr_vpn,
    input  wire logic [7:0]           wr_space_id,
    input  wire logic                 lk_valid,
    input  wire logic [19:0]          lk_vpn,
    input  wire logic [7:0]           lk_space_id,
    input  wire logic [1:0]           lk_kind,
    output logic                      lk_hit,
    output logic                      lk_miss,
    output logic                      lk_invalid_fault,
    output logic                      lk_modified_fault,
    output logic      [31:0]          lk_phys_addr,
    output tvp_pkg::tvp_mtype_t       lk_mtype
);
    import tvp_pkg::*;

    // Register map, one word per offset: victim index at 0x00,
    // read only; even and odd page attributes at 0x04 and 0x08;
    // pinned entry count at 0x0C, whose write also restarts the
    // victim index; control at 0x10; capability at 0x14. Any
    // other offset draws an error answer instead of an ack.
    // The TLB instruction and lookup ports are one-cycle strobes
    // from the pipeline on this same clock, so no synchroniser.

    // lk_kind: 0 load, 1 store, 2 fetch.
    // Code 3 is unused; it meets only the valid check.
    localparam logic [1:0] KIND_STORE = 2'h1;
    localparam logic [1:0] KIND_FETCH = 2'h2;

    logic [IDX_W-1:0] victim_q;
    logic [IDX_W-1:0] pinned_q;
    logic [4:0]       lfsr_q;
    logic [31:0]      even_q;
    logic [31:0]      odd_q;
    logic [2:0]       ctl_q;
    logic             cap_sp_q;
    logic             ack_q;
    logic [31:0]      rdata_q;
    logic             err_q;

    // Attribute word layout, shared by both page registers:
    // bit 31 load inhibit, bit 30 fetch block, bits 29:26
    // spare and stored as written, bits 25:6 frame number,
    // bits 5:3 memory type, bit 2 store permit, bit 1 valid,
    // bit 0 shared flag.
    // Entry array: tag, space id, shared flag, and two page halves.
    // The array keeps whole attribute words, but a read gives
    // back bit 0 as the entry's stored shared flag, not as written.
    logic [18:0] ent_vpn_q   [TLB_ENTRIES];
    logic [7:0]  ent_sid_q   [TLB_ENTRIES];
    logic        ent_shr_q   [TLB_ENTRIES];
    logic [31:0] ent_even_q  [TLB_ENTRIES];
    logic [31:0] ent_odd_q   [TLB_ENTRIES];

    // ==========================================================
    // Wishbone slave
    // A single wait-free ack the cycle after the strobe; the gap after
    // ack keeps back-to-back cycles from being counted twice.
    // A request is taken on the edge where it is first seen;
    // ack or err stands for the next cycle only. A master that
    // holds its request through ack is not taken twice,
    // because the request gate looks at the pending answer.
    logic bus_req;
    logic bus_wr;
    logic adr_ok;
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    assign bus_wr  = bus_req && wb_we_i && adr_ok;
    assign adr_ok  = (wb_adr_i == OFS_VICTIM) || (wb_adr_i == OFS_EVEN) ||
                     (wb_adr_i == OFS_ODD) || (wb_adr_i == OFS_PINNED) ||
                     (wb_adr_i == OFS_CTL) || (wb_adr_i == OFS_CAP);

    // Byte-lane merge for writable registers.
    // Lanes with sel low keep their old bytes, so software may
    // change one byte of an attribute word without a read first.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Answer: ack for mapped addresses, err for unmapped.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ack_q <= bus_req && adr_ok;
            err_q <= bus_req && !adr_ok;
        end
    end

    // Read data; a read of the victim index has no side effect.
    // The default arm only serves the error path, whose data
    // no master is allowed to use.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            unique case (wb_adr_i)
                OFS_VICTIM: rdata_q <= 32'(victim_q);
                OFS_EVEN:   rdata_q <= even_q;
                OFS_ODD:    rdata_q <= odd_q;
                OFS_PINNED: rdata_q <= 32'(pinned_q);
                OFS_CTL:    rdata_q <= 32'(ctl_q);
                OFS_CAP:    rdata_q <= 32'(cap_sp_q);
                default:    rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Bus outputs come straight from flip-flops.
    assign wb_dat_o = rdata_q;
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;

    // ==========================================================
    // Victim index
    logic pinned_wr;
    assign pinned_wr = bus_wr && (wb_adr_i == OFS_PINNED);

    // The index walks down from the top entry to the pinned count
    // and then jumps back to the top. Entries below the pinned
    // count are never reached, so they stay safe from random
    // replacement. A pinned count at the top parks the index on
    // the last entry. The value is only read, never consumed,
    // so a bus read does not disturb the sequence.
    logic [IDX_W-1:0] victim_d;
    always_comb begin
        victim_d = victim_q;
        if (!lfsr_q[0]) begin
            if (victim_q <= pinned_q) begin
                victim_d = IDX_TOP;
            end else begin
                victim_d = victim_q - 1'b1;
            end
        end
    end

    // Writes to the victim index offset are acked and dropped.
    always_ff @(posedge core_clk) begin
        if (rst || pinned_wr) begin
            victim_q <= IDX_TOP;
        end else begin
            victim_q <= victim_d;
        end
    end

    // Pinned entry count; only the index bits are kept.
    // Upper bits of the written word are dropped without error.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pinned_q <= '0;
        end else if (pinned_wr && wb_sel_i[0]) begin
            pinned_q <= wb_dat_i[IDX_W-1:0];
        end
    end

    // Galois LFSR, x^5 + x^3 + 1; a stall on about half of cycles.
    // The seed is non-zero and the polynomial is primitive, so
    // the register never locks up at zero. Stalling this often
    // trades walking speed for an index that software cannot
    // easily predict or fall into step with.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lfsr_q <= LFSR_SEED;
        end else begin
            lfsr_q <= {lfsr_q[0], lfsr_q[4], lfsr_q[3] ^ lfsr_q[0], lfsr_q[2:1]};
        end
    end

    // ==========================================================
    // Control and capability
    // Control bit 0 arms load inhibit, bit 1 arms fetch block and
    // bit 2 asks for small pages. The capability bit is writable
    // so that a test can switch small pages in; a product build
    // would tie it to the configured value.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctl_q    <= 3'h0;
            cap_sp_q <= 1'b0;
        end else begin
            if (bus_wr && wb_adr_i == OFS_CTL && wb_sel_i[0]) begin
                ctl_q <= wb_dat_i[2:0];
            end
            if (bus_wr && wb_adr_i == OFS_CAP && wb_sel_i[0]) begin
                cap_sp_q <= wb_dat_i[0];
            end
        end
    end

    // ==========================================================
    // Page attribute registers
    // Software writes are stored as given; the four bits above the
    // frame number are left to software to zero.
    // A TLB read in the same cycle as a bus write wins, because
    // the pipeline's own instruction must not be half overwritten
    // by a store from software that lands on the same edge.
    logic [IDX_W-1:0] rd_idx;
    assign rd_idx = entry_index;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            even_q <= ATTR_RST;
            odd_q  <= ATTR_RST;
        end else if (tlb_read_entry) begin
            even_q <= {ent_even_q[rd_idx][31:1], ent_shr_q[rd_idx]};
            odd_q  <= {ent_odd_q[rd_idx][31:1], ent_shr_q[rd_idx]};
        end else begin
            if (bus_wr && wb_adr_i == OFS_EVEN) begin
                even_q <= merge(even_q, wb_dat_i, wb_sel_i);
            end
            if (bus_wr && wb_adr_i == OFS_ODD) begin
                odd_q <= merge(odd_q, wb_dat_i, wb_sel_i);
            end
        end
    end

    // ==========================================================
    // Entry array write
    logic [IDX_W-1:0] wr_idx;
    logic             wr_en;
    assign wr_idx = tlb_write_victim ? victim_q : entry_index;
    assign wr_en  = tlb_write_victim || tlb_write_indexed;

    // No reset: the array content is defined by software before use.
    // A random write takes the index as it stands at the edge of
    // the pulse; the index may step on that same edge, which is
    // harmless since only the old value is used.
    // The stored shared flag needs both halves to be shared.
    // Lookups see a new entry from the cycle after the write.
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            ent_vpn_q[wr_idx]  <= wr_vpn;
            ent_sid_q[wr_idx]  <= wr_space_id;
            ent_shr_q[wr_idx]  <= even_q[ATTR_SHARED] & odd_q[ATTR_SHARED];
            ent_even_q[wr_idx] <= even_q;
            ent_odd_q[wr_idx]  <= odd_q;
        end
    end

    // ==========================================================
    // Lookup, one cycle registered
    // Every entry compares its tag against the upper virtual page
    // bits; bit 0 of the page number picks the even or odd half.
    // A shared entry matches any space id. When software leaves
    // two entries matching, the lowest index wins; this keeps the
    // result defined but hides the duplicate from software.
    logic [TLB_ENTRIES-1:0] match;
    genvar g;
    generate
        for (g = 0; g < TLB_ENTRIES; g++) begin : g_match
            assign match[g] = (ent_vpn_q[g] == lk_vpn[19:1]) &&
                              (ent_shr_q[g] || ent_sid_q[g] == lk_space_id);
        end
    endgenerate

    logic [31:0] page;
    logic        any_hit;
    always_comb begin
        page    = 32'h0000_0000;
        any_hit = 1'b0;
        for (int i = 0; i < TLB_ENTRIES; i++) begin
            if (match[i] && !any_hit) begin
                any_hit = 1'b1;
                page    = lk_vpn[0] ? ent_odd_q[i] : ent_even_q[i];
            end
        end
    end

    logic inv;
    logic modf;
    logic [31:0] pa;
    tvp_mtype_t  mt;
    // Fault checks: invalid takes priority over modified, so a
    // store to an invalid page reports only the invalid fault.
    // The inhibit bits only count while their enable is set;
    // otherwise they behave as reserved zero bits.
    // Frame number placement follows the small-page setting.
    always_comb begin
        inv = !page[ATTR_VALID];
        if (ctl_q[CTL_LI_EN] && page[ATTR_LOAD_INH] && lk_kind == 2'h0) begin
            inv = 1'b1;
        end
        if (ctl_q[CTL_FB_EN] && page[ATTR_FETCH_BLK] && lk_kind == KIND_FETCH) begin
            inv = 1'b1;
        end
        modf = !inv && lk_kind == KIND_STORE && !page[ATTR_STORE_OK];
        // Offset bits of the page come from the virtual side upstream.
        if (cap_sp_q && ctl_q[CTL_SP_EN]) begin
            pa = {2'b00, page[ATTR_FN_HI:ATTR_FN_LO], 10'h000};
        end else begin
            pa = {page[ATTR_FN_HI:ATTR_FN_LO], 12'h000};
        end
        unique case (page[ATTR_MT_HI:ATTR_MT_LO])
            3'h0:    mt = MT_WT_NOALLOC;
            3'h1:    mt = MT_WT_ALLOC;
            3'h2:    mt = MT_UNCACHED;
            3'h7:    mt = MT_UNCACHED;
            default: mt = MT_WB_ALLOC;
        endcase
    end

    // Results stand one cycle after the lookup request.
    // The flags are gated by the lookup strobe so that they pulse
    // once; the address and type follow the array every cycle and
    // are only meaningful while the hit flag stands.
    // A miss leaves both fault flags low.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lk_hit            <= 1'b0;
            lk_miss           <= 1'b0;
            lk_invalid_fault  <= 1'b0;
            lk_modified_fault <= 1'b0;
            lk_phys_addr      <= 32'h0000_0000;
            lk_mtype          <= MT_WT_NOALLOC;
        end else begin
            lk_hit            <= lk_valid && any_hit;
            lk_miss           <= lk_valid && !any_hit;
            lk_invalid_fault  <= lk_valid && any_hit && inv;
            lk_modified_fault <= lk_valid && any_hit && modf;
            lk_phys_addr      <= pa;
            lk_mtype          <= mt;
        end
    end
endmodule : tvp_core
`default_nettype wire

// [tb/tvp_core_props.sv]
// Checker for the tvp_core bus answer and lookup result timing.
// Assumes it is bound to tvp_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker
module tvp_core_props (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [7:0]  wb_adr_i,
    input wire logic        wb_we_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        lk_valid,
    input wire logic [1:0]  lk_kind,
    input wire logic        lk_hit,
    input wire logic        lk_miss,
    input wire logic        lk_invalid_fault,
    input wire logic        lk_modified_fault
);
    import tvp_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic mapped;
    // Misaligned offsets count as unmapped, so they must draw an error.
    assign mapped = wb_adr_i inside {OFS_VICTIM, OFS_EVEN, OFS_ODD, OFS_PINNED, OFS_CTL, OFS_CAP};
    property p_ack_time;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o;
    endproperty
    a_ack_time: assert property (p_ack_time) else $error("bus answer late");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_vic_ro;
        wb_ack_o && !wb_we_i && wb_adr_i == OFS_VICTIM |-> wb_dat_o[31:5] == 27'h0;
    endproperty
    a_vic_ro: assert property (p_vic_ro) else $error("victim upper bits set");
    property p_err_map; wb_err_o |-> !mapped; endproperty
    a_err_map: assert property (p_err_map) else $error("error on mapped");
    property p_lk_ans; lk_valid |=> lk_hit ^ lk_miss; endproperty
    a_lk_ans: assert property (p_lk_ans) else $error("lookup unanswered");
    property p_lk_idle;
        !lk_valid |=> !(lk_hit || lk_miss || lk_invalid_fault || lk_modified_fault);
    endproperty
    a_lk_idle: assert property (p_lk_idle) else $error("stray lookup flag");
    property p_mod_store;
        lk_modified_fault |-> $past(lk_kind) == 2'h1 && !lk_invalid_fault;
    endproperty
    a_mod_store: assert property (p_mod_store) else $error("bad modified");
    property p_fault_hit; lk_invalid_fault || lk_modified_fault |-> !lk_miss; endproperty
    a_fault_hit: assert property (p_fault_hit) else $error("fault on miss");
    c_err: cover property (wb_err_o);
    c_inv: cover property (lk_invalid_fault);
    c_mod: cover property (lk_modified_fault);
endmodule : tvp_core_props
bind tvp_core tvp_core_props i_tvp_core_props (.*);
`default_nettype wire

// [tb/tvp_pipe_model.sv]
// Pipeline stand-in issuing TLB instructions and lookups.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Pipeline model
module tvp_pipe_model (
    input  wire logic        core_clk,
    output logic             tlb_write_victim,
    output logic             tlb_write_indexed,
    output logic             tlb_read_entry,
    output logic [4:0]       entry_index,
    output logic [18:0]      wr_vpn,
    output logic [7:0]       wr_space_id,
    output logic             lk_valid,
    output logic [19:0]      lk_vpn,
    output logic [7:0]       lk_space_id,
    output logic [1:0]       lk_kind
);
    // Everything quiet at time zero.
    initial begin
        {tlb_write_victim, tlb_write_indexed, tlb_read_entry, lk_valid} = 4'h0;
        {entry_index, wr_vpn, wr_space_id, lk_vpn, lk_space_id, lk_kind} = 62'h0;
    end
    // One-cycle pulse; k is 0 random write, 1 indexed write, 2 read.
    task automatic op(input int k, input logic [4:0] i, input logic [18:0] v);
        @(posedge core_clk);
        {tlb_write_victim, tlb_write_indexed, tlb_read_entry} <= {k == 0, k == 1, k == 2};
        {entry_index, wr_vpn, wr_space_id} <= {i, v, v[7:0]};
        @(posedge core_clk);
        {tlb_write_victim, tlb_write_indexed, tlb_read_entry} <= 3'h0;
        // Tag is scrambled once taken so nothing leans on it lingering.
        wr_vpn <= ~v;
    endtask : op
    // Lookup pulse; returns while the registered answer stands.
    task automatic look(input logic [19:0] v, input logic [7:0] s, input logic [1:0] k);
        @(posedge core_clk);
        {lk_valid, lk_vpn, lk_space_id, lk_kind} <= {1'b1, v, s, k};
        @(posedge core_clk);
        {lk_valid, lk_vpn} <= {1'b0, ~v};
        #1;
    endtask : look
endmodule : tvp_pipe_model
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for tvp_core with the pipeline model.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench top
module testbench;
    import tvp_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, rd, wb_dat_o, lk_phys_addr;
    logic [3:0]  wb_sel_i = 4'hF;
    logic er, wb_ack_o, wb_err_o, lk_hit, lk_miss, lk_invalid_fault, lk_modified_fault;
    logic tlb_write_victim, tlb_write_indexed, tlb_read_entry, lk_valid;
    logic [4:0]  entry_index;
    logic [18:0] wr_vpn;
    logic [7:0]  wr_space_id, lk_space_id;
    logic [19:0] lk_vpn;
    logic [1:0]  lk_kind;
    tvp_mtype_t  lk_mtype;
    int n_fail = 0, samples_checked = 0;
    int mt[8] = '{0, 1, 2, 3, 3, 3, 3, 2};
    localparam logic [18:0] VP = 19'h1234A;
    tvp_core i_tvp_core (.*);
    tvp_pipe_model i_tvp_pipe_model (.*);
    always #10 core_clk = ~core_clk;
    // ==========
    // Shared tasks
    task automatic finish_test();
        if (n_fail == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Classic single cycle, held until ack or err is sampled.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 16);
        {rd, er} = {wb_dat_o, wb_err_o};
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (n >= 16) chk(32'h0, 32'h1);
    endtask : wb
    // Lookup, then miss, invalid and modified flags against e.
    task automatic lk(input logic [19:0] v, input logic [7:0] s, input logic [1:0] k,
                      input logic [2:0] e);
        logic [3:0] f;
        i_tvp_pipe_model.look(v, s, k);
        f = {lk_hit, lk_miss, lk_invalid_fault, lk_modified_fault};
        chk({28'h0, f}, {28'h0, ~e[2], e});
    endtask : lk
    function automatic logic [31:0] at(logic li, logic xi, logic [19:0] f, logic [2:0] c,
                                       logic [2:0] dvg);
        return {li, xi, 4'h0, f, c, dvg};
    endfunction : at
    // ==========
    // Scenarios
    task automatic t_regs();
        wb(0, OFS_EVEN, 0);
        chk(rd, ATTR_RST);
        wb(1, OFS_VICTIM, 32'hFFFF_FFFF);
        wb(0, OFS_VICTIM, 0);
        chk(rd >> 5, 0);
        wb(1, 8'h40, 0);
        chk({31'h0, er}, 1);
        wb(1, OFS_EVEN, 32'hC3FF_FFFF);
        wb_sel_i <= 4'h1;
        wb(1, OFS_EVEN, 0);
        wb_sel_i <= 4'hF;
        wb(0, OFS_EVEN, 0);
        chk(rd, 32'hC3FF_FF00);
    endtask : t_regs
    // Ring 20..31; three cycles pass between reads, so a gap below three means a stall.
    task automatic t_victim();
        logic [31:0] p;
        int d, st;
        st = 0;
        wb(1, OFS_PINNED, 32'd20);
        wb(0, OFS_VICTIM, 0);
        p = rd;
        chk(32'(p >= 28 && p <= 31), 1);
        for (int k = 0; k < 40; k++) begin
            wb(0, OFS_VICTIM, 0);
            d = (int'(p) - int'(rd) + 12) % 12;
            chk(32'(rd >= 20 && rd <= 31), 1);
            chk(32'(d <= 3), 1);
            if (d < 3) st++;
            p = rd;
        end
        chk(32'(st > 0), 1);
        chk(32'(st < 40), 1);
    endtask : t_victim
    task automatic t_tlb();
        logic [31:0] ev, od;
        ev = at(0, 0, 20'h12345, 3'd5, 3'b011);
        od = at(0, 0, 20'h00ABC, 3'd2, 3'b100);
        for (int i = 0; i < 32; i++)
            i_tvp_pipe_model.op(1, 5'(i), 19'(i) | 19'h40000);
        wb(1, OFS_EVEN, ev);
        wb(1, OFS_ODD, od);
        i_tvp_pipe_model.op(1, 5'd3, VP);
        wb(1, OFS_EVEN, 0);
        i_tvp_pipe_model.op(2, 5'd3, 0);
        wb(0, OFS_EVEN, 0);
        chk(rd, ev & ~32'h1);
        wb(0, OFS_ODD, 0);
        chk(rd, od);
        lk({VP, 1'b0}, 8'h4A, 2'd0, 3'b000);
        chk({12'h0, lk_phys_addr[31:12]}, 32'h12345);
        chk({30'h0, lk_mtype}, 32'h3);
        lk({VP, 1'b0}, 8'h4A, 2'd1, 3'b001);
        lk({VP, 1'b1}, 8'h4A, 2'd0, 3'b010);
        lk({VP, 1'b0}, 8'h4B, 2'd0, 3'b100);
    endtask : t_tlb
    // After faulting lookups only the even attribute register is rewritten, never read.
    task automatic t_modes();
        wb(1, OFS_EVEN, at(0, 1, 20'h12345, 3'd3, 3'b111));
        wb(1, OFS_ODD, at(1, 0, 20'h00ABC, 3'd3, 3'b111));
        i_tvp_pipe_model.op(1, 5'd3, VP);
        wb(1, OFS_CTL, 32'h3);
        lk({VP, 1'b1}, 8'h4A, 2'd0, 3'b010);
        lk({VP, 1'b0}, 8'h4A, 2'd2, 3'b010);
        lk({VP, 1'b0}, 8'h77, 2'd1, 3'b000);
        wb(1, OFS_CTL, 32'h0);
        lk({VP, 1'b1}, 8'h4A, 2'd0, 3'b000);
        lk({VP, 1'b0}, 8'h4A, 2'd2, 3'b000);
        wb(1, OFS_CAP, 32'h1);
        wb(1, OFS_CTL, 32'h4);
        lk({VP, 1'b0}, 8'h4A, 2'd0, 3'b000);
        chk({12'h0, lk_phys_addr[29:10]}, 32'h12345);
        wb(1, OFS_CTL, 32'h0);
        for (int c = 0; c < 8; c++) begin
            wb(1, OFS_EVEN, at(0, 0, 20'h1, 3'(c), 3'b011));
            i_tvp_pipe_model.op(1, 5'd3, VP);
            lk({VP, 1'b0}, 8'h4A, 2'd0, 3'b000);
            chk({30'h0, lk_mtype}, 32'(mt[c]));
        end
    endtask : t_modes
    // With the pin at the top the victim can only be entry 31.
    task automatic t_random();
        wb(1, OFS_PINNED, 32'd31);
        wb(1, OFS_EVEN, at(0, 0, 20'hBEEF1, 3'd1, 3'b111));
        i_tvp_pipe_model.op(0, 5'd0, 19'h7FFFF);
        wb(1, OFS_EVEN, 0);
        i_tvp_pipe_model.op(2, 5'd31, 0);
        wb(0, OFS_EVEN, 0);
        chk(rd, at(0, 0, 20'hBEEF1, 3'd1, 3'b111));
    endtask : t_random
    // ==========
    // Main sequence and watchdog
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_victim();
        t_tlb();
        t_modes();
        t_random();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        finish_test();
    end
endmodule : testbench
`default_nettype wire
